/* include/acrb_div_if.sv */
// Interface between the control bank and its converter clock divider.
`timescale 1ns/1ps
interface acrb_div_if;
  logic       run;
  logic [2:0] code;
  logic       tick;
  modport ctl (output run, output code, input tick);
  modport div (input run, input code, output tick);
endinterface

/* include/acrb_pkg.sv */
// Constants, field layouts and encodings of the converter control bank.
package acrb_pkg;
  // ****************************************************************
  // Bus and register map.
  // ****************************************************************
  localparam int         ADDR_W      = 12;
  localparam logic [5:0] OFF_CR0     = 6'h00;
  localparam logic [5:0] OFF_CR1     = 6'h04;
  localparam logic [5:0] OFF_START   = 6'h08;
  localparam logic [5:0] OFF_SQR     = 6'h0c;
  localparam logic [5:0] OFF_CR2     = 6'h10;
  localparam logic [5:0] OFF_VTH     = 6'h14;
  localparam logic [5:0] OFF_VTL     = 6'h18;
  localparam logic [5:0] OFF_TRIG    = 6'h1c;
  localparam logic [5:0] OFF_RES_A   = 6'h20;
  localparam logic [5:0] OFF_RES_B   = 6'h24;
  localparam logic [5:0] OFF_RES_C   = 6'h28;
  localparam logic [5:0] OFF_RES_D   = 6'h2c;
  localparam logic [5:0] OFF_ACC     = 6'h30;
  localparam logic [5:0] OFF_IER     = 6'h34;
  localparam logic [5:0] OFF_ICR     = 6'h38;
  localparam logic [5:0] OFF_ISR     = 6'h3c;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Primary control word layout.
  // ****************************************************************
  localparam logic [31:0] CR0_RESET = 32'h00000000;
  localparam logic [31:0] CR0_MASK  = 32'h0000ffff;
  localparam int          EN_BIT    = 0;
  localparam int          MODE_LO   = 1;
  localparam int          BG_BIT    = 4;
  localparam int          TS_BIT    = 5;
  localparam int          REF_LO    = 6;
  localparam int          CLK_LO    = 8;
  localparam int          SAM_LO    = 11;
  localparam int          BUF_BIT   = 13;
  localparam int          TRIM_LO   = 14;

  // ****************************************************************
  // Other control registers.
  // ****************************************************************
  localparam logic [31:0] REG_RESET  = 32'h00000000;
  localparam logic [31:0] CR2_MASK   = 32'h000001ff;
  localparam int          ACCRST_BIT = 9;
  localparam int          START_BIT  = 0;

  // ****************************************************************
  // Mode, reference and acquisition encodings.
  // ****************************************************************
  localparam logic [2:0] MODE_SGL_ONE   = 3'h0;
  localparam logic [2:0] MODE_SGL_MULTI = 3'h1;
  localparam logic [2:0] MODE_SGL_CONT  = 3'h2;
  localparam logic [2:0] MODE_SEQ_CONT  = 3'h3;
  localparam logic [2:0] MODE_SEQ_SCAN  = 3'h4;
  localparam logic [2:0] MODE_SEQ_MULTI = 3'h5;
  localparam logic [2:0] MODE_SEQ_INTM  = 3'h6;
  localparam logic [1:0] REF_INT_LOW    = 2'h0;
  localparam logic [1:0] REF_INT_HIGH   = 2'h1;
  localparam logic [1:0] REF_EXT_PIN    = 2'h2;
  localparam logic [1:0] REF_SUPPLY     = 2'h3;
  localparam logic [3:0] ACQ_CYC_0      = 4'h5;
  localparam logic [3:0] ACQ_CYC_1      = 4'h6;
  localparam logic [3:0] ACQ_CYC_2      = 4'h8;
  localparam logic [3:0] ACQ_CYC_3      = 4'ha;

  // ****************************************************************
  // Interrupt status layout.
  // ****************************************************************
  localparam int         EV_N      = 7;
  localparam int         READY_BIT = 8;
  localparam logic [6:0] EV_RESET  = 7'h00;
endpackage

/* rtl/acrb_clk_div.sv */
// Converter clock divider producing one tick per divided clock period.
`timescale 1ns/1ps
module acrb_clk_div (
  input  wire logic core_clk,
  input  wire logic rstn,
  acrb_div_if.div   divPort
);
  logic [6:0] count;
  logic [6:0] limit;

  // ****************************************************************
  // Divide ratio.
  // ****************************************************************
  // Limit one below a power of two.
  assign limit = 7'((8'h01 << divPort.code) - 8'h01);

  // ****************************************************************
  // Counter and tick.
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      count        <= 7'h00;
      divPort.tick <= 1'b0;
    end else if (!divPort.run) begin
      count        <= 7'h00;
      divPort.tick <= 1'b0;
    end else if (count >= limit) begin
      count        <= 7'h00;
      divPort.tick <= 1'b1;
    end else begin
      count        <= count + 7'h01;
      divPort.tick <= 1'b0;
    end
  end
endmodule // acrb_clk_div

/* rtl/acrb_top.sv */
// Converter control register bank with AXI4-Lite slave and interrupt logic.
`timescale 1ns/1ps
module acrb_top (
  input  wire logic                        core_clk,
  input  wire logic                        rstn,
  input  wire logic [acrb_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                        awvalid,
  output wire logic                        awready,
  input  wire logic [31:0]                 wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output wire logic                        wready,
  output logic      [1:0]                  bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  input  wire logic [acrb_pkg::ADDR_W-1:0] araddr,
  input  wire logic                        arvalid,
  output wire logic                        arready,
  output logic      [31:0]                 rdata,
  output logic      [1:0]                  rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  input  wire logic                        coreReady,
  input  wire logic [acrb_pkg::EV_N-1:0]   coreEvents,
  input  wire logic [15:0]                 resultA,
  input  wire logic [15:0]                 resultB,
  input  wire logic [15:0]                 resultC,
  input  wire logic [15:0]                 resultD,
  input  wire logic [31:0]                 accResult,
  output logic                             converterEnable,
  output logic      [3:0]                  acqCycles,
  output logic      [3:0]                  refSource,
  output logic      [2:0]                  modeSelect,
  output logic                             modeValid,
  output logic      [8:0]                  conversionsPerRun,
  output logic                             thermalProbeEnable,
  output logic                             bandgapEnable,
  output logic                             followerEnable,
  output logic      [1:0]                  analogTrim,
  output wire logic                        converterClkTick,
  output logic                             convStart,
  output logic                             accClear,
  output logic      [31:0]                 secondaryCtrl,
  output logic      [31:0]                 sequenceCfg,
  output logic      [31:0]                 upperThreshold,
  output logic      [31:0]                 lowerThreshold,
  output logic      [31:0]                 triggerSelect,
  output wire logic                        irq
);
  import acrb_pkg::*;

  logic [31:0]      controlPrimary;
  logic [31:0]      controlSecondary;
  logic [31:0]      startReg;
  logic [31:0]      sequenceReg;
  logic [31:0]      controlTertiary;
  logic [31:0]      upperReg;
  logic [31:0]      lowerReg;
  logic [31:0]      triggerReg;
  logic [EV_N-1:0]  intEnable;
  logic [EV_N-1:0]  intStatus;
  logic [EV_N-1:0]  next_intStatus;
  logic             awHeld;
  logic             wHeld;
  logic [ADDR_W-1:0] wrAddr;
  logic [31:0]      wrData;
  logic [3:0]       wrStrb;
  logic             doWrite;
  logic             wrMapped;
  logic [5:0]       wrOff;
  logic             rdTake;
  logic [5:0]       rdOff;
  logic [31:0]      rdWord;
  logic             readySync1;
  logic             readySync2;
  logic             readyFlag;
  logic [EV_N-1:0]  clearMask;

  acrb_div_if divBus ();

  // ****************************************************************
  // Helper functions.
  // ****************************************************************
  function automatic logic [31:0] merge(input logic [31:0] oldVal, input logic [31:0] newVal,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[i*8 +: 8] = newVal[i*8 +: 8];
    end
    return res;
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] addr);
    return addr[ADDR_W-1:6] == '0;
  endfunction

  // ****************************************************************
  // AXI4-Lite write channel.
  // ****************************************************************
  assign awready  = !awHeld && !bvalid;
  assign wready   = !wHeld && !bvalid;
  assign doWrite  = awHeld && wHeld && !bvalid;
  assign wrMapped = mapped(wrAddr);
  assign wrOff    = {wrAddr[5:2], 2'b00};

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      awHeld <= 1'b0;
      wrAddr <= '0;
    end else if (awvalid && awready) begin
      awHeld <= 1'b1;
      wrAddr <= awaddr;
    end else if (doWrite) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wHeld  <= 1'b0;
      wrData <= 32'h00000000;
      wrStrb <= 4'h0;
    end else if (wvalid && wready) begin
      wHeld  <= 1'b1;
      wrData <= wdata;
      wrStrb <= wstrb;
    end else if (doWrite) begin
      wHeld <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      bresp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Control registers.
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      controlPrimary <= CR0_RESET;
    end else if (doWrite && wrMapped && wrOff == OFF_CR0) begin
      controlPrimary <= merge(controlPrimary, wrData, wrStrb) & CR0_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      controlSecondary <= REG_RESET;
      sequenceReg      <= REG_RESET;
      controlTertiary  <= REG_RESET;
      upperReg         <= REG_RESET;
      lowerReg         <= REG_RESET;
      triggerReg       <= REG_RESET;
      startReg         <= REG_RESET;
    end else if (doWrite && wrMapped) begin
      case (wrOff)
        OFF_CR1:   controlSecondary <= merge(controlSecondary, wrData, wrStrb);
        OFF_SQR:   sequenceReg      <= merge(sequenceReg, wrData, wrStrb);
        OFF_CR2:   controlTertiary  <= merge(controlTertiary, wrData, wrStrb) & CR2_MASK;
        OFF_VTH:   upperReg         <= merge(upperReg, wrData, wrStrb);
        OFF_VTL:   lowerReg         <= merge(lowerReg, wrData, wrStrb);
        OFF_TRIG:  triggerReg       <= merge(triggerReg, wrData, wrStrb);
        OFF_START: startReg         <= merge(startReg, wrData, wrStrb);
        default: begin end
      endcase
    end
  end

  // ****************************************************************
  // Command pulses.
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      convStart <= 1'b0;
      accClear  <= 1'b0;
    end else begin
      convStart <= doWrite && wrMapped && wrOff == OFF_START && wrStrb[0]
                   && wrData[START_BIT] && converterEnable && readyFlag
                   && modeValid;
      accClear  <= doWrite && wrMapped && wrOff == OFF_CR2 && wrStrb[1]
                   && wrData[ACCRST_BIT];
    end
  end

  // ****************************************************************
  // Ready synchroniser.
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      readySync1 <= 1'b0;
      readySync2 <= 1'b0;
    end else begin
      readySync1 <= coreReady;
      readySync2 <= readySync1;
    end
  end

  assign readyFlag = readySync2 && controlPrimary[EN_BIT];

  // ****************************************************************
  // Decoded outputs to the analog core.
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      converterEnable    <= 1'b0;
      acqCycles          <= ACQ_CYC_0;
      refSource          <= 4'h1;
      modeSelect         <= MODE_SGL_ONE;
      modeValid          <= 1'b1;
      conversionsPerRun  <= 9'h001;
      thermalProbeEnable <= 1'b0;
      bandgapEnable      <= 1'b0;
      followerEnable     <= 1'b0;
      analogTrim         <= 2'h0;
    end else begin
      converterEnable <= controlPrimary[EN_BIT];
      case (controlPrimary[SAM_LO +: 2])
        2'h0:    acqCycles <= ACQ_CYC_0;
        2'h1:    acqCycles <= ACQ_CYC_1;
        2'h2:    acqCycles <= ACQ_CYC_2;
        default: acqCycles <= ACQ_CYC_3;
      endcase
      refSource <= 4'(4'h1 << controlPrimary[REF_LO +: 2]);
      modeSelect <= controlPrimary[MODE_LO +: 3];
      modeValid  <= controlPrimary[MODE_LO +: 3] <= MODE_SEQ_INTM;
      case (controlPrimary[MODE_LO +: 3])
        MODE_SGL_MULTI, MODE_SEQ_MULTI: conversionsPerRun <= {1'b0, controlTertiary[7:0]} + 9'h001;
        MODE_SGL_ONE, MODE_SGL_CONT, MODE_SEQ_CONT, MODE_SEQ_SCAN,
        MODE_SEQ_INTM: conversionsPerRun <= 9'h001;
        default: conversionsPerRun <= 9'h000;
      endcase
      thermalProbeEnable <= controlPrimary[TS_BIT];
      bandgapEnable  <= controlPrimary[BG_BIT];
      followerEnable <= controlPrimary[BUF_BIT];
      analogTrim     <= controlPrimary[TRIM_LO +: 2];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      secondaryCtrl  <= REG_RESET;
      sequenceCfg    <= REG_RESET;
      upperThreshold <= REG_RESET;
      lowerThreshold <= REG_RESET;
      triggerSelect  <= REG_RESET;
    end else begin
      secondaryCtrl  <= controlSecondary;
      sequenceCfg    <= sequenceReg;
      upperThreshold <= upperReg;
      lowerThreshold <= lowerReg;
      triggerSelect  <= triggerReg;
    end
  end

  // ****************************************************************
  // Converter clock divider.
  // ****************************************************************
  // Divider steered by clock field.
  assign divBus.run       = controlPrimary[EN_BIT];
  assign divBus.code      = controlPrimary[CLK_LO +: 3];
  assign converterClkTick = divBus.tick;

  acrb_clk_div i_acrb_clk_div (
    .core_clk (core_clk),
    .rstn     (rstn),
    .divPort  (divBus.div)
  );

  // ****************************************************************
  // Interrupt status, mask and clear.
  // ****************************************************************
  always_comb begin
    clearMask = '0;
    if (rdTake && mapped(araddr) && rdOff == OFF_ISR) begin
      clearMask = '1;
    end
    if (doWrite && wrMapped && wrOff == OFF_ICR && wrStrb[0]) begin
      clearMask = clearMask | ~wrData[EV_N-1:0];
    end
    next_intStatus = (intStatus & ~clearMask) | coreEvents;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      intStatus <= EV_RESET;
    end else begin
      intStatus <= next_intStatus;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      intEnable <= EV_RESET;
    end else if (doWrite && wrMapped && wrOff == OFF_IER) begin
      intEnable <= wrStrb[0] ? wrData[EV_N-1:0] : intEnable;
    end
  end

  assign irq = |(intStatus & intEnable);

  // ****************************************************************
  // AXI4-Lite read channel.
  // ****************************************************************
  assign arready = !rvalid;
  assign rdTake  = arvalid && arready;
  assign rdOff   = {araddr[5:2], 2'b00};

  always_comb begin
    rdWord = 32'h00000000;
    case (rdOff)
      OFF_CR0:   rdWord = controlPrimary;
      OFF_CR1:   rdWord = controlSecondary;
      OFF_START: rdWord = startReg;
      OFF_SQR:   rdWord = sequenceReg;
      OFF_CR2:   rdWord = controlTertiary;
      OFF_VTH:   rdWord = upperReg;
      OFF_VTL:   rdWord = lowerReg;
      OFF_TRIG:  rdWord = triggerReg;
      OFF_RES_A: rdWord = {16'h0000, resultA};
      OFF_RES_B: rdWord = {16'h0000, resultB};
      OFF_RES_C: rdWord = {16'h0000, resultC};
      OFF_RES_D: rdWord = {16'h0000, resultD};
      OFF_ACC:   rdWord = accResult;
      OFF_IER:   rdWord = {25'h0, intEnable};
      OFF_ICR:   rdWord = 32'h00000000;
      OFF_ISR:   rdWord = {23'h0, readyFlag, 1'b0, intStatus};
      default:   rdWord = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= RESP_OKAY;
    end else if (rdTake) begin
      rvalid <= 1'b1;
      rdata  <= mapped(araddr) ? rdWord : 32'h00000000;
      rresp  <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule // acrb_top

/* testbench/acrb_core_model.sv */
// Behavioural analog core facing the control bank.
`timescale 1ns/1ps
module acrb_core_model (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        converterEnable,
  input  wire logic        convStart,
  output logic             coreReady,
  output logic      [6:0]  coreEvents,
  output logic      [15:0] resultA,
  output logic      [15:0] resultB,
  output logic      [15:0] resultC,
  output logic      [15:0] resultD,
  output logic      [31:0] accResult
);
  logic [4:0] upCnt;
  logic [2:0] convPipe;
  assign resultA = 16'hc1a0;
  assign resultB = 16'hc1a1;
  assign resultC = 16'hc1a2;
  assign resultD = 16'hc1a3;
  assign accResult = 32'h5e0c1a04;
  assign coreEvents = {6'h00, convPipe[2]};
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      upCnt <= 5'h00;
      coreReady <= 1'b0;
    end else if (!converterEnable) begin
      upCnt <= 5'h00;
      coreReady <= 1'b0;
    end else if (upCnt == 5'h14) begin
      coreReady <= 1'b1;
    end else begin
      upCnt <= upCnt + 5'h01;
    end
  end
  // End of conversion a few cycles after each start.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      convPipe <= 3'h0;
    end else begin
      convPipe <= {convPipe[1:0], convStart};
    end
  end
endmodule // acrb_core_model

/* testbench/acrb_top_asserts.sv */
// Concurrent checks on the control bank ports.
`timescale 1ns/1ps
module acrb_top_asserts (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic [3:0]  acqCycles,
  input wire logic [3:0]  refSource,
  input wire logic [2:0]  modeSelect,
  input wire logic        modeValid,
  input wire logic [8:0]  conversionsPerRun,
  input wire logic        convStart,
  input wire logic        converterEnable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_startOk; converterEnable && modeValid ##1 !convStart; endsequence
  sequence s_bHeld; bvalid && $stable(bresp); endsequence
  sequence s_rHeld; rvalid && $stable(rdata); endsequence
  property p_acq; acqCycles inside {4'h5, 4'h6, 4'h8, 4'ha}; endproperty
  property p_ref; $onehot(refSource); endproperty
  property p_mode; modeValid == (modeSelect != 3'h7); endproperty
  property p_runsNone; !modeValid |-> conversionsPerRun == 9'h000; endproperty
  property p_runsOne;
    modeValid && !(modeSelect inside {3'h1, 3'h5}) |-> conversionsPerRun == 9'h001;
  endproperty
  property p_start; convStart |-> s_startOk; endproperty
  property p_bHold; bvalid && !bready |=> s_bHeld; endproperty
  property p_rHold; rvalid && !rready |=> s_rHeld; endproperty
  a_acq: assert property (p_acq)
    else $error("acquisition length outside its set");
  a_ref: assert property (p_ref)
    else $error("reference select not one-hot");
  a_mode: assert property (p_mode)
    else $error("mode valid flag wrong");
  a_runsNone: assert property (p_runsNone)
    else $error("undefined mode runs conversions");
  a_runsOne: assert property (p_runsOne)
    else $error("single run count wrong");
  a_start: assert property (p_start)
    else $error("start pulse without enable or too long");
  a_bHold: assert property (p_bHold)
    else $error("write response dropped early");
  a_rHold: assert property (p_rHold)
    else $error("read data dropped early");
endmodule // acrb_top_asserts
bind acrb_top acrb_top_asserts i_acrb_top_asserts (.core_clk(core_clk), .rstn(rstn),
  .bvalid(bvalid), .bready(bready), .bresp(bresp), .rvalid(rvalid), .rready(rready),
  .rdata(rdata), .acqCycles(acqCycles), .refSource(refSource), .modeSelect(modeSelect),
  .modeValid(modeValid), .conversionsPerRun(conversionsPerRun), .convStart(convStart),
  .converterEnable(converterEnable));

/* testbench/acrb_top_test.sv */
// Self-checking bench for the converter control bank.
`timescale 1ns/1ps
module acrb_top_test;
  import acrb_pkg::*;
  logic core_clk = 1'b0, rstn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rd, exp, c;
  logic [3:0] wstrb = 4'hf, acqCycles, refSource;
  logic awready, wready, arready, bvalid, rvalid, converterEnable, modeValid, irq, coreReady;
  logic thermalProbeEnable, bandgapEnable, followerEnable, converterClkTick, convStart, accClear;
  logic [1:0] bresp, rresp, rr, analogTrim, br;
  logic [2:0] modeSelect;
  logic [8:0] conversionsPerRun;
  logic [6:0] coreEvents;
  logic [15:0] resultA, resultB, resultC, resultD;
  logic [31:0] rdata, secondaryCtrl, sequenceCfg, upperThreshold, lowerThreshold;
  logic [31:0] triggerSelect, accResult;
  int nFail = 0, nTests = 0, nStart = 0, nClr = 0, i, k;
  acrb_top i_acrb_top (.*);
  acrb_core_model i_acrb_core_model (.*);
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) if (convStart === 1'b1) nStart <= nStart + 1;
  always @(posedge core_clk) if (accClear === 1'b1) nClr <= nClr + 1;
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    nTests++;
    if (seen !== want) begin
      nFail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic hang(input int n);
    if (n >= 200) begin
      nFail++;
      summarize();
    end
  endtask
  task automatic axiWr(input logic [11:0] a, input logic [31:0] d);
    logic aw, w, b;
    int n;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(negedge core_clk);
      aw = awvalid & awready;
      w = wvalid & wready;
      b = bvalid & bready;
      if (b) br = bresp;
      @(posedge core_clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) break;
    end
    bready <= 1'b0;
    hang(n);
  endtask
  task automatic axiRd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, got;
    int n;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(negedge core_clk);
      ar = arvalid & arready;
      got = rvalid & rready;
      d = rdata;
      r = rresp;
      @(posedge core_clk);
      if (ar) arvalid <= 1'b0;
      if (got) break;
    end
    rready <= 1'b0;
    hang(n);
  endtask
  task automatic tickGap(output int n);
    for (n = 1; n < 300; n++) begin
      @(negedge core_clk);
      if (converterClkTick === 1'b1) break;
    end
    hang(n);
  endtask
  function automatic logic [3:0] acqOf(input logic [1:0] s);
    return (s == 2'h0) ? 4'h5 : (s == 2'h1) ? 4'h6 : (s == 2'h2) ? 4'h8 : 4'ha;
  endfunction
  function automatic logic [8:0] runsOf(input logic [2:0] m, input logic [7:0] n);
    return (m == 3'h7) ? 9'h000 : (m == 3'h1 || m == 3'h5) ? {1'b0, n} + 9'h001 : 9'h001;
  endfunction
  initial begin
    void'($urandom(24838));
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    axiRd(12'h000, rd, rr);
    chk(rd, CR0_RESET);
    chk({converterEnable, acqCycles, refSource, modeSelect}, {1'b0, 4'h5, 4'h1, 3'h0});
    $display("reset test done");
    for (i = 0; i < 16; i++) begin
      c = $urandom();
      axiWr(12'h010, {24'h000000, c[7:0]});
      exp = {18'h00000, c[17:8], i[2:0], c[0]};
      axiWr(12'h000, exp);
      axiRd(12'h000, rd, rr);
      chk(rd, exp);
      @(negedge core_clk);
      chk(acqCycles, acqOf(exp[12:11]));
      chk(refSource, 4'h1 << exp[7:6]);
      chk({modeValid, modeSelect}, {i[2:0] != 3'h7, i[2:0]});
      chk(conversionsPerRun, runsOf(i[2:0], c[7:0]));
      chk({thermalProbeEnable, bandgapEnable}, exp[5:4]);
      chk({analogTrim, followerEnable, converterEnable}, {exp[15:13], exp[0]});
    end
    $display("control word test done");
    for (i = 0; i < 8; i++) begin
      axiWr(12'h000, 32'h1 | (i << 8));
      tickGap(k);
      tickGap(k);
      chk(k, 1 << i);
    end
    $display("clock divider test done");
    axiWr(12'h000, 32'h0);
    axiWr(12'h000, 32'h1);
    axiRd(12'h03c, rd, rr);
    chk(rd[8], 1'b0);
    for (k = 0; k < 100 && rd[8] !== 1'b1; k++) axiRd(12'h03c, rd, rr);
    if (rd[8] !== 1'b1) hang(200);
    chk(rd[8], 1'b1);
    k = nStart;
    axiWr(12'h034, 32'h1);
    axiWr(12'h008, 32'h1);
    repeat (6) @(negedge core_clk);
    chk(nStart - k, 1);
    chk(irq, 1'b1);
    axiRd(12'h03c, rd, rr);
    chk(rd, 32'h101);
    @(negedge core_clk);
    chk(irq, 1'b0);
    axiWr(12'h034, 32'h0);
    axiWr(12'h008, 32'h1);
    repeat (6) @(negedge core_clk);
    chk(irq, 1'b0);
    axiWr(12'h038, 32'h0);
    axiRd(12'h03c, rd, rr);
    chk(rd, 32'h100);
    axiWr(12'h000, 32'hf);
    k = nStart;
    axiWr(12'h008, 32'h1);
    repeat (4) @(negedge core_clk);
    chk(nStart - k, 0);
    $display("ready and interrupt test done");
    for (i = 0; i < 5; i++) begin
      axiRd(12'h020 + 12'(4 * i), rd, rr);
      chk(rd, (i < 4) ? 32'h0000c1a0 + i : 32'h5e0c1a04);
      chk(rr, RESP_OKAY);
    end
    axiRd(12'h040, rd, rr);
    chk(rr, RESP_SLVERR);
    chk(rd, 32'h0);
    axiWr(12'h040, 32'h1);
    chk(br, RESP_SLVERR);
    axiRd(12'h000, rd, rr);
    chk(rd, 32'hf);
    c = $urandom();
    axiWr(12'h004, c);
    chk(br, RESP_OKAY);
    axiWr(12'h00c, ~c);
    axiWr(12'h014, c ^ 32'h00ff00ff);
    axiWr(12'h018, c ^ 32'hff00ff00);
    axiWr(12'h01c, c ^ 32'h0f0f0f0f);
    k = nClr;
    axiWr(12'h010, 32'h200);
    axiRd(12'h010, rd, rr);
    chk(rd, 32'h0);
    chk(nClr - k, 1);
    chk(secondaryCtrl, c);
    chk(sequenceCfg, ~c);
    chk(upperThreshold, c ^ 32'h00ff00ff);
    chk(lowerThreshold, c ^ 32'hff00ff00);
    chk(triggerSelect, c ^ 32'h0f0f0f0f);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    axiRd(12'h000, rd, rr);
    chk(rd, CR0_RESET);
    $display("result map test done");
    summarize();
  end
endmodule // acrb_top_test
